// ### hdl/bth_pkg.sv
// constants and helpers for the type-one bridge configuration header block
// assumes a dword-aligned configuration access port with byte enables
package bth_pkg;

  // byte offsets of the header registers in configuration space
  localparam logic [7:0] UPSTREAM_LATENCY_OFS = 8'h0D;
  localparam logic [7:0] HEADER_LAYOUT_OFS = 8'h0E;
  localparam logic [7:0] SELF_TEST_OFS = 8'h0F;
  localparam logic [7:0] CONTROL_WINDOW_OFS = 8'h10;
  localparam logic [7:0] UPSTREAM_BUS_OFS = 8'h18;
  localparam logic [7:0] DOWNSTREAM_BUS_OFS = 8'h19;
  localparam logic [7:0] HIGHEST_BUS_OFS = 8'h1A;
  localparam logic [7:0] DS_LATENCY_OFS = 8'h1B;
  localparam logic [7:0] IO_WINDOW_BOTTOM_OFS = 8'h1C;

  // fixed read values and reset values
  localparam logic [7:0] UPSTREAM_LATENCY_VAL = 8'h00;
  localparam logic [7:0] HEADER_LAYOUT_VAL = 8'h01;
  localparam logic [7:0] SELF_TEST_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
  localparam logic [7:0] BUS_BYTE_RESET = 8'h00;
  localparam logic [19:0] CONTROL_WINDOW_RESET = 20'h00000;
  localparam logic [3:0] IO_BOTTOM_RESET = 4'h0;
  localparam logic [3:0] IO_ADDRESSING_WIDTH_CODE = 4'h1;

  // field positions
  localparam int CW_ADDR_LSB = 12;
  localparam int CW_ADDR_W = 20;
  localparam int IO_BOTTOM_LSB = 4;
  localparam logic [7:0] CW_RESERVED_BITS = 8'h00;
  localparam logic [3:0] CW_SPACE_LOW_BITS = 4'h0;

  // fill of the low twelve address bits of the I/O window
  localparam logic [11:0] IO_BOTTOM_FILL = 12'h000;
  localparam logic [11:0] IO_TOP_FILL = 12'hFFF;

  // read data appears this many cycles after the read strobe
  localparam int READ_LATENCY = 1;

  // what the bridge does with a type 1 configuration request
  typedef enum logic [1:0] {
    T1_IGNORE,
    T1_TO_TYPE0,
    T1_PASS_TYPE1
  } bth_t1_type;

  // true when the access addresses the dword of ofs and enables its lane
  function automatic logic lane_hit(input logic [7:0] addr,
                                    input logic [3:0] be,
                                    input logic [7:0] ofs);
    return (addr[7:2] == ofs[7:2]) && be[ofs[1:0]];
  endfunction

  // true when the access addresses the dword that holds ofs
  function automatic logic dword_hit(input logic [7:0] addr,
                                     input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction

endpackage

// ### hdl/bth_io_window.sv
// I/O window compare: is an address inside the assembled base..limit range
// assumes the caller registers the result; purely combinational here
`timescale 1ns/1ps

module bth_io_window #(
  parameter int ADDR_W = 32
) (
  input wire logic [ADDR_W-17:0] base_upper,
  input wire logic [3:0] base_nibble,
  input wire logic [ADDR_W-17:0] limit_upper,
  input wire logic [3:0] limit_nibble,
  input wire logic [ADDR_W-1:0] addr,
  output logic hit
);
  import bth_pkg::*;

  logic [ADDR_W-1:0] bottom;
  logic [ADDR_W-1:0] top;

  // bottom fills low bits with zeros, top with ones
  assign bottom = {base_upper, base_nibble, IO_BOTTOM_FILL};
  assign top = {limit_upper, limit_nibble, IO_TOP_FILL};
  // an empty window (bottom above top) claims nothing
  assign hit = (addr >= bottom) && (addr <= top);

endmodule

// ### hdl/bth_cfg_header.sv
// type-one bridge configuration header, bytes 0Dh through 1Ch
// assumes single-cycle configuration strobes synchronous to clk
`timescale 1ns/1ps

module bth_cfg_header #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  input wire logic base_unlock,
  input wire logic [ADDR_W-17:0] io_base_upper,
  input wire logic [3:0] io_limit_nibble,
  input wire logic [ADDR_W-17:0] io_limit_upper,
  input wire logic io_req_valid,
  input wire logic [ADDR_W-1:0] io_req_addr,
  output logic io_claim_valid,
  output logic io_claim,
  input wire logic t1_req_valid,
  input wire logic [7:0] t1_req_bus,
  output logic t1_done,
  output bth_pkg::bth_t1_type t1_outcome,
  output logic [bth_pkg::CW_ADDR_W-1:0] control_window_base,
  output logic [7:0] upstream_bus_number,
  output logic [7:0] downstream_bus_number,
  output logic [7:0] highest_downstream_bus,
  output logic [7:0] downstream_latency_timer,
  output logic [3:0] io_range_bottom_bits
);
  import bth_pkg::*;

  logic [7:0] bus_byte [4];
  logic [7:0] bus_ofs [4];
  logic hit_header;
  logic hit_window;
  logic hit_bus;
  logic hit_io;
  logic cw_write;
  logic io_write;
  logic [CW_ADDR_W-1:0] next_cw;
  logic [31:0] next_rdata;
  logic window_hit;
  logic t1_is_local;
  logic t1_is_below;
  bth_t1_type next_t1_outcome;

  // the bus-number dword holds four independent read/write bytes
  assign bus_ofs[0] = UPSTREAM_BUS_OFS;
  assign bus_ofs[1] = DOWNSTREAM_BUS_OFS;
  assign bus_ofs[2] = HIGHEST_BUS_OFS;
  assign bus_ofs[3] = DS_LATENCY_OFS;

  // dword decode for reads
  assign hit_header = dword_hit(cfg_addr, HEADER_LAYOUT_OFS);
  assign hit_window = dword_hit(cfg_addr, CONTROL_WINDOW_OFS);
  assign hit_bus = dword_hit(cfg_addr, UPSTREAM_BUS_OFS);
  assign hit_io = dword_hit(cfg_addr, IO_WINDOW_BOTTOM_OFS);

  // window base takes writes only while unlocked; lane 0 holds no
  // writable bits so only lanes 1..3 matter
  assign cw_write = cfg_wr && hit_window && base_unlock;
  assign next_cw = {
    cfg_be[3] ? cfg_wdata[31:24] : control_window_base[19:12],
    cfg_be[2] ? cfg_wdata[23:16] : control_window_base[11:4],
    cfg_be[1] ? cfg_wdata[15:12] : control_window_base[3:0]
  };

  // only the upper nibble of the I/O bottom byte is writable
  assign io_write = cfg_wr &&
                    lane_hit(cfg_addr, cfg_be, IO_WINDOW_BOTTOM_OFS);

  // read mux; constant fields are built here, never stored, so a
  // write cannot disturb them
  assign next_rdata =
    hit_header ? {SELF_TEST_VAL, HEADER_LAYOUT_VAL,
                  UPSTREAM_LATENCY_VAL, UNMAPPED_BYTE} :
    hit_window ? {control_window_base, CW_RESERVED_BITS,
                  CW_SPACE_LOW_BITS} :
    hit_bus ? {bus_byte[3], bus_byte[2], bus_byte[1], bus_byte[0]} :
    hit_io ? {UNMAPPED_BYTE, UNMAPPED_BYTE, UNMAPPED_BYTE,
              io_range_bottom_bits, IO_ADDRESSING_WIDTH_CODE} :
    {UNMAPPED_BYTE, UNMAPPED_BYTE, UNMAPPED_BYTE, UNMAPPED_BYTE};

  // type 1 decode against downstream and highest bus numbers
  assign t1_is_local = t1_req_bus == downstream_bus_number;
  assign t1_is_below = (t1_req_bus > downstream_bus_number) &&
                       (t1_req_bus <= highest_downstream_bus);
  assign next_t1_outcome = t1_is_local ? T1_TO_TYPE0 :
                           t1_is_below ? T1_PASS_TYPE1 : T1_IGNORE;

  // I/O window compare
  bth_io_window #(
    .ADDR_W(ADDR_W)
  ) u_window (
    .base_upper(io_base_upper),
    .base_nibble(io_range_bottom_bits),
    .limit_upper(io_limit_upper),
    .limit_nibble(io_limit_nibble),
    .addr(io_req_addr),
    .hit(window_hit)
  );

  // bus-number bytes, one per lane
  for (genvar l = 0; l < 4; l++) begin : g_bus
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        bus_byte[l] <= BUS_BYTE_RESET;
      end else if (cfg_wr && lane_hit(cfg_addr, cfg_be, bus_ofs[l])) begin
        bus_byte[l] <= cfg_wdata[8*l +: 8];
      end
    end
  end

  assign upstream_bus_number = bus_byte[0];
  assign downstream_bus_number = bus_byte[1];
  assign highest_downstream_bus = bus_byte[2];
  assign downstream_latency_timer = bus_byte[3];

  // window base register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control_window_base <= CONTROL_WINDOW_RESET;
    end else if (cw_write) begin
      control_window_base <= next_cw;
    end
  end

  // I/O bottom nibble; byte 1Ch sits in lane 0 of its dword, so the
  // writable nibble is taken from wdata bits 7:4
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_range_bottom_bits <= IO_BOTTOM_RESET;
    end else if (io_write) begin
      io_range_bottom_bits <= cfg_wdata[IO_BOTTOM_LSB +: 4];
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rd_valid <= 1'b0;
      cfg_rdata <= 32'h00000000;
    end else begin
      cfg_rd_valid <= cfg_rd;
      cfg_rdata <= cfg_rd ? next_rdata : 32'h00000000;
    end
  end

  // I/O claim decision, registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_claim_valid <= 1'b0;
      io_claim <= 1'b0;
    end else begin
      io_claim_valid <= io_req_valid;
      io_claim <= io_req_valid && window_hit;
    end
  end

  // type 1 decision, registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t1_done <= 1'b0;
      t1_outcome <= T1_IGNORE;
    end else begin
      t1_done <= t1_req_valid;
      t1_outcome <= t1_req_valid ? next_t1_outcome : T1_IGNORE;
    end
  end

  // read-path checks on the fixed header bytes; the expected values are
  // written as literals so a slip in the package would still show up
  a_latency_byte_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_rd && hit_header |-> ##1 cfg_rd_valid && cfg_rdata[15:8] == 8'h00)
    else $error("latency byte not zero");

  a_header_layout_val: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_rd && hit_header |-> ##1 cfg_rdata[23:16] == 8'h01)
    else $error("header layout byte wrong");

  a_self_test_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_rd && hit_header |-> ##1 cfg_rdata[31:24] == 8'h00)
    else $error("self-test byte not zero");

  // window base checks: locked, unlocked and low-lane writes
  a_base_locked_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    !base_unlock |=> $stable(control_window_base))
    else $error("window base changed while locked");

  a_base_unlocked_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_wr && base_unlock && cfg_addr == 8'h10 && cfg_be == 4'hF
    |=> control_window_base == $past(cfg_wdata[31:12]))
    else $error("unlocked base write lost");

  // lane 0 of the window dword holds only constant bits
  a_base_lane0_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_be == 4'h1 |=> $stable(control_window_base))
    else $error("window base changed by low lane write");

  a_base_low_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_rd && hit_window |-> ##1 cfg_rdata[11:0] == 12'h000)
    else $error("window base low bits not zero");

  // bus number and I/O bottom byte checks
  a_bus_byte_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == 8'h18 && cfg_be == 4'hF
    |=> {downstream_latency_timer, highest_downstream_bus,
         downstream_bus_number, upstream_bus_number} == $past(cfg_wdata))
    else $error("bus number dword write lost");

  a_bus_lane_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_wr && !cfg_be[0] |=> $stable(upstream_bus_number))
    else $error("upstream bus byte changed without its lane");

  a_io_type_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_rd && hit_io |-> ##1 cfg_rdata[3:0] == 4'h1 &&
    cfg_rdata[7:4] == io_range_bottom_bits)
    else $error("io bottom byte read wrong");

  a_io_bottom_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == 8'h1C && cfg_be[0]
    |=> io_range_bottom_bits == $past(cfg_wdata[7:4]))
    else $error("io bottom nibble write lost");

  // classification checks for I/O and type 1 requests
  a_io_claim_range: assert property (
    @(posedge clk) disable iff (!arst_n)
    io_req_valid |=> io_claim_valid && io_claim ==
    ($past(io_req_addr) >= {$past(io_base_upper),
      $past(io_range_bottom_bits), 12'h000} &&
     $past(io_req_addr) <= {$past(io_limit_upper),
      $past(io_limit_nibble), 12'hFFF}))
    else $error("io claim disagrees with window");

  a_claim_idle_low: assert property (
    @(posedge clk) disable iff (!arst_n)
    !io_req_valid |=> !io_claim_valid && !io_claim)
    else $error("io claim raised without a request");

  a_t1_local_bus: assert property (
    @(posedge clk) disable iff (!arst_n)
    t1_req_valid && t1_req_bus == downstream_bus_number
    |=> t1_done && t1_outcome == T1_TO_TYPE0)
    else $error("type 1 to local bus not converted");

  a_t1_pass_below: assert property (
    @(posedge clk) disable iff (!arst_n)
    t1_req_valid && t1_req_bus > downstream_bus_number &&
    t1_req_bus <= highest_downstream_bus
    |=> t1_done && t1_outcome == T1_PASS_TYPE1)
    else $error("type 1 below local bus not passed on");

  a_t1_ignore_outside: assert property (
    @(posedge clk) disable iff (!arst_n)
    t1_req_valid && t1_req_bus != downstream_bus_number &&
    (t1_req_bus < downstream_bus_number ||
     t1_req_bus > highest_downstream_bus)
    |=> t1_done && t1_outcome == T1_IGNORE)
    else $error("type 1 outside bus range not ignored");

  // scenario covers
  c_unlocked_write: cover property (@(posedge clk) disable iff (!arst_n)
    cw_write ##1 control_window_base != CONTROL_WINDOW_RESET);
  c_io_claimed: cover property (@(posedge clk) disable iff (!arst_n)
    io_claim_valid && io_claim);
  c_t1_converted: cover property (@(posedge clk) disable iff (!arst_n)
    t1_done && t1_outcome == T1_TO_TYPE0);
  c_t1_passed: cover property (@(posedge clk) disable iff (!arst_n)
    t1_done && t1_outcome == T1_PASS_TYPE1);
  c_header_read: cover property (@(posedge clk) disable iff (!arst_n)
    cfg_rd && hit_header ##1 cfg_rd_valid);

endmodule

// ### verif/bth_host_model.sv
// host configuration software model: drives the config strobes
// assumes one caller process and a free-running clk from the bench
`timescale 1ns/1ps

module bth_host_model (
  input wire logic clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_valid
);
  // idle bus at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end

  // released address and data lines flip so a stale value is never mistaken for data
  task automatic idle();
    cfg_addr = ~cfg_addr;
    cfg_wdata = ~cfg_wdata;
  endtask

  // one-cycle write strobe, changed only at falling edges
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    idle();
  endtask

  // answer stands from the taking edge on, sampled half a cycle later at the falling edge
  task automatic rd(input logic [7:0] a, output logic [32:0] got);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge clk);
    cfg_rd = 1'b0;
    got = {cfg_rd_valid, cfg_rdata};
    idle();
  endtask

  // software keeps the highest bus equal to the downstream bus
  task automatic set_buses(input logic [7:0] up, input logic [7:0] ds,
                           input logic [7:0] lat);
    wr(8'h18, 4'hF, {lat, ds, ds, up});
  endtask
endmodule

// ### verif/bridge_type1_config_header_bench.sv
// self-checking bench for the type-one bridge header block
// assumes bth_pkg and the host model are compiled first
`timescale 1ns/1ps

module bridge_type1_config_header_bench;
  import bth_pkg::*;
  logic clk, arst_n, cfg_wr, cfg_rd, cfg_rd_valid, base_unlock;
  logic io_req_valid, io_claim_valid, io_claim, t1_req_valid, t1_done;
  logic [7:0] cfg_addr, t1_req_bus, upstream_bus_number, ds, hi;
  logic [7:0] downstream_bus_number, highest_downstream_bus;
  logic [7:0] downstream_latency_timer;
  logic [3:0] cfg_be, io_limit_nibble, io_range_bottom_bits, io_nib;
  logic [31:0] cfg_wdata, cfg_rdata, io_req_addr;
  logic [15:0] io_base_upper, io_limit_upper;
  logic [19:0] control_window_base;
  bth_t1_type t1_outcome;
  int failures = 0, total_checks = 0, cycles = 0;

  bth_cfg_header dut (.clk, .arst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .base_unlock, .io_base_upper,
    .io_limit_nibble, .io_limit_upper, .io_req_valid, .io_req_addr,
    .io_claim_valid, .io_claim, .t1_req_valid, .t1_req_bus, .t1_done,
    .t1_outcome, .control_window_base, .upstream_bus_number,
    .downstream_bus_number, .highest_downstream_bus,
    .downstream_latency_timer, .io_range_bottom_bits);
  bth_host_model host (.clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_rd_valid);

  always #20 clk = ~clk;

  // hang guard, far above the roughly 160 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cls(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // byte-lane merge of a write into the expected dword
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] be);
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        o[8*k +: 8] = d[8*k +: 8];
      end
    end
    return o;
  endfunction

  function automatic logic in_io(input logic [31:0] a);
    return a >= {io_base_upper, io_nib, 12'h000} &&
           a <= {io_limit_upper, io_limit_nibble, 12'hFFF};
  endfunction

  function automatic logic [1:0] t1_exp(input logic [7:0] b);
    if (b == ds) begin
      return T1_TO_TYPE0;
    end
    if (b > ds && b <= hi) begin
      return T1_PASS_TYPE1;
    end
    return T1_IGNORE;
  endfunction

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [32:0] got;
    host.rd(a, got);
    check_reg(got, {1'b1, exp});
  endtask

  task automatic io_cls(input logic [31:0] a);
    @(negedge clk);
    io_req_valid = 1'b1;
    io_req_addr = a;
    @(negedge clk);
    io_req_valid = 1'b0;
    io_req_addr = ~a;
    check_cls({io_claim_valid, 1'b0, io_claim}, {2'b10, in_io(a)});
  endtask

  task automatic t1_cls(input logic [7:0] b);
    @(negedge clk);
    t1_req_valid = 1'b1;
    t1_req_bus = b;
    @(negedge clk);
    t1_req_valid = 1'b0;
    t1_req_bus = ~b;
    check_cls({t1_done, t1_outcome}, {1'b1, t1_exp(b)});
  endtask

  initial begin
    logic [31:0] w, shadow;
    logic [3:0] be;
    logic [31:0] bot, top;
    w = $urandom(32'hAED44BCC);
    clk = 1'b0;
    arst_n = 1'b0;
    base_unlock = 1'b0;
    {io_req_valid, t1_req_valid, io_req_addr, t1_req_bus} = '0;
    {io_base_upper, io_limit_upper, io_limit_nibble} = '0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    rd_chk(8'h0C, 32'h0001_0000);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h1C, 32'h1);
    rd_chk(8'h20, 32'h0);
    host.wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
    rd_chk(8'h0C, 32'h0001_0000);
    // window base: locked, unlocked, low lane only, locked again
    host.wr(8'h10, 4'hF, $urandom | 32'h1000);
    rd_chk(8'h10, 32'h0);
    base_unlock = 1'b1;
    w = $urandom;
    host.wr(8'h10, 4'hF, w);
    rd_chk(8'h10, {w[31:12], 12'h000});
    check_reg(33'(control_window_base), 33'(w[31:12]));
    host.wr(8'h10, 4'h1, ~w);
    rd_chk(8'h10, {w[31:12], 12'h000});
    base_unlock = 1'b0;
    host.wr(8'h10, 4'hF, ~w);
    rd_chk(8'h10, {w[31:12], 12'h000});
    // bus number bytes under random lane enables
    shadow = 32'h0;
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      be = 4'($urandom);
      host.wr(8'h18, be, w);
      shadow = merge(shadow, w, be);
      rd_chk(8'h18, shadow);
    end
    check_reg({1'b0, downstream_latency_timer, highest_downstream_bus,
      downstream_bus_number, upstream_bus_number}, {1'b0, shadow});
    // I/O window edges; round 0 may give an empty range
    for (int r = 0; r < 4; r++) begin
      w = $urandom;
      host.wr(8'h1C, 4'h1, w);
      io_nib = w[7:4];
      rd_chk(8'h1C, {24'h0, w[7:4], 4'h1});
      check_reg(33'(io_range_bottom_bits), 33'(io_nib));
      io_base_upper = 16'($urandom);
      io_limit_upper = io_base_upper + 16'(r);
      io_limit_nibble = 4'($urandom);
      bot = {io_base_upper, io_nib, 12'h000};
      top = {io_limit_upper, io_limit_nibble, 12'hFFF};
      io_cls(bot - 1);
      io_cls(bot);
      io_cls(top);
      io_cls(top + 1);
      io_cls({io_base_upper, 16'($urandom)});
    end
    // type 1 steering, then a wider range to reach the pass case
    ds = 8'($urandom) & 8'h7F | 8'h04;
    hi = ds;
    host.set_buses(8'($urandom), ds, 8'($urandom));
    for (int b = -1; b < 2; b++) begin
      t1_cls(ds + 8'(b));
    end
    hi = ds + 8'h02;
    host.wr(8'h18, 4'h4, {8'h00, hi, 16'h0000});
    for (int b = 1; b < 4; b++) begin
      t1_cls(ds + 8'(b));
    end
    end_sim();
  end
endmodule
